// [rtl/sus_pkg.sv]
package sus_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_ZS_THRESHOLD = 8'h00;
    localparam logic [7:0] ADDR_PC_RANGE = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_DETECT_TIME = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVENT = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_CONTROL = 8'h1C;

    // Field positions in the mode register.
    localparam int MODE_PC_LSB = 0;
    localparam int MODE_UV_BIT = 4;

    // Event bit positions, shared by the event and mask registers.
    localparam int EV_ZERO_SPEED = 0;
    localparam int EV_POS_COMPLETE = 1;
    localparam int EV_POWER_LOST = 2;
    localparam int EV_UV_ERROR = 3;
    localparam int EV_WIDTH = 4;

    // Control register bit that clears a latched undervoltage error.
    localparam int CTRL_CLR_ERR_BIT = 0;

    // Setting limits and reset values.
    localparam logic [14:0] ZS_THRESHOLD_MIN = 15'h000A;
    localparam logic [14:0] ZS_THRESHOLD_MAX = 15'h4E20;
    localparam logic [14:0] ZS_THRESHOLD_RST = 15'h0032;
    localparam logic [14:0] ZS_HYST_RPM = 15'h000A;
    localparam logic [14:0] PC_RANGE_RST = 15'h0083;
    localparam logic [1:0] PC_MODE_RST = 2'h0;
    localparam logic UV_SELECT_RST = 1'b1;
    localparam logic [9:0] DETECT_TIME_RST = 10'h046;
    localparam logic [9:0] DETECT_TIME_OFF = 10'h3E8;

    // Detection time unit and its length in clock cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int DETECT_UNIT_MS = 1;
    localparam int DETECT_UNIT_CYCLES = DETECT_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    // Positioning-complete modes.
    typedef enum logic [1:0] {
        PC_ALWAYS = 2'h0,
        PC_NO_CMD = 2'h1,
        PC_NO_CMD_ZS = 2'h2,
        PC_HOLD = 2'h3
    } sus_pc_mode_type;

    // Main power supervision states.
    typedef enum logic [2:0] {
        PWR_OK = 3'b001,
        PWR_COUNT = 3'b010,
        PWR_LOST = 3'b100
    } sus_pwr_state_type;

    // Magnitude of a signed value, used for speed and deviation.
    function automatic logic [31:0] sus_abs(input logic signed [31:0] v);
        sus_abs = v[31] ? 32'(-v) : 32'(v);
    endfunction

endpackage

// [rtl/sus_zero_speed.sv]
`timescale 1ns/1ns
module sus_zero_speed (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic NRST_I,
    // Speed and threshold.
    input wire logic signed [15:0] speed_i,
    input wire logic [14:0] threshold_i,
    // Detector output.
    output logic zero_speed_o
);
    import sus_pkg::*;

    logic [31:0] speed_mag;
    logic [31:0] release_level;
    logic zero_speed_reg;
    logic chk_on_reg;

    // Direction does not matter, only magnitude is compared.
    assign speed_mag = sus_abs(32'(speed_i));
    assign release_level = 32'(threshold_i) + 32'(ZS_HYST_RPM);

    // Assert below threshold, release only at or above threshold plus band, so noise near the edge cannot chatter.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            zero_speed_reg <= 1'b0;
        end else if (speed_mag < 32'(threshold_i)) begin
            zero_speed_reg <= 1'b1;
        end else if (speed_mag >= release_level) begin
            zero_speed_reg <= 1'b0;
        end
    end

    assign zero_speed_o = zero_speed_reg;

    // Checks start one edge after reset release, because the edge that releases reset still loads reset values.
    always_ff @(posedge CLK_I) begin
        chk_on_reg <= NRST_I;
    end

    property p_zs_set;
        @(posedge CLK_I) disable iff (!chk_on_reg) (speed_mag < 32'(threshold_i)) |=> zero_speed_reg;
    endproperty
    a_zs_set: assert property (p_zs_set) else $error("Zero speed not set below threshold.");

    property p_zs_hold;
        @(posedge CLK_I) disable iff (!chk_on_reg)
            (zero_speed_reg && speed_mag < release_level) |=> zero_speed_reg;
    endproperty
    a_zs_hold: assert property (p_zs_hold) else $error("Zero speed dropped inside band.");

    property p_zs_clear;
        @(posedge CLK_I) disable iff (!chk_on_reg) (speed_mag >= release_level) |=> !zero_speed_reg;
    endproperty
    a_zs_clear: assert property (p_zs_clear) else $error("Zero speed kept above band.");

endmodule

// [rtl/sus_top.sv]
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module sus_top #(
    parameter int TICK_CYCLES = sus_pkg::DETECT_UNIT_CYCLES,
    parameter int DEV_WIDTH = 24
) (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic NRST_I,
    // AHB-Lite slave.
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Motion inputs from the control loop.
    input wire logic signed [15:0] SPEED_I,
    input wire logic signed [DEV_WIDTH-1:0] DEVIATION_I,
    input wire logic POS_CMD_ACTIVE_I,
    input wire logic SERVO_ON_REQ_I,
    // Power stage pins.
    input wire logic MAIN_POWER_OK_I,
    input wire logic DC_BUS_LOW_I,
    // Status outputs.
    output logic ZERO_SPEED_OUT_O,
    output logic POSITION_COMPLETE_OUT_O,
    output logic SERVO_ENABLE_O,
    output logic MAIN_UNDERVOLTAGE_ERROR_O,
    output logic IRQ_O
);
    import sus_pkg::*;

    // Elaboration refuses widths that the magnitude function and the tick counter cannot serve.
    if (TICK_CYCLES < 1 || DEV_WIDTH < 16 || DEV_WIDTH > 32) begin : g_param_check
        $error("Unsupported sus_top parameters.");
    end

    logic [14:0] zs_threshold_reg;
    logic [14:0] pc_range_reg;
    logic [1:0] pc_mode_reg;
    logic uv_select_reg;
    logic [9:0] detect_time_reg;
    logic [EV_WIDTH-1:0] event_reg;
    logic [EV_WIDTH-1:0] mask_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_reg;
    logic pwr_sync1_reg, pwr_sync2_reg, bus_sync1_reg, bus_sync2_reg;
    sus_pwr_state_type pwr_state_reg;
    logic [31:0] tick_cnt_reg;
    logic [9:0] off_time_reg;
    logic error_reg;
    logic pc_out_reg;
    logic pc_held_reg;
    logic cmd_prev_reg;
    logic zs_prev_reg, pc_prev_reg, lost_prev_reg, err_prev_reg;
    logic servo_en_reg;
    logic zero_speed;
    logic addr_phase;
    logic [14:0] wdata_thr;
    logic in_range;
    logic no_cmd_ok;
    logic pc_cond;
    logic power_lost;
    logic err_clear;
    logic err_set;
    logic [EV_WIDTH-1:0] ev_set;
    logic chk_on_reg;

    // Zero-speed detection with hysteresis lives in its own module.
    sus_zero_speed u_zero_speed (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .speed_i(SPEED_I),
        .threshold_i(zs_threshold_reg),
        .zero_speed_o(zero_speed)
    );

    // The slave never inserts wait states and always answers OKAY.
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_reg;
    assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1] && (HSIZE_I == 3'h2);

    // Address phase capture; only whole-word transfers are served, others are ignored.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (HREADY_I) begin
            wr_pend_reg <= addr_phase && HWRITE_I;
            rd_pend_reg <= addr_phase && !HWRITE_I;
            addr_reg <= HADDR_I[7:0];
        end
    end

    // Read data is prepared at the address phase so it stands through the data phase.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE_I) begin
            if (HADDR_I[7:0] == ADDR_ZS_THRESHOLD) begin
                rdata_reg <= 32'(zs_threshold_reg);
            end else if (HADDR_I[7:0] == ADDR_PC_RANGE) begin
                rdata_reg <= 32'(pc_range_reg);
            end else if (HADDR_I[7:0] == ADDR_MODE) begin
                rdata_reg <= (32'(uv_select_reg) << MODE_UV_BIT) | (32'(pc_mode_reg) << MODE_PC_LSB);
            end else if (HADDR_I[7:0] == ADDR_DETECT_TIME) begin
                rdata_reg <= 32'(detect_time_reg);
            end else if (HADDR_I[7:0] == ADDR_STATUS) begin
                rdata_reg <= 32'({error_reg, power_lost, pc_out_reg, zero_speed}) | (32'(servo_en_reg) << 4);
            end else if (HADDR_I[7:0] == ADDR_EVENT) begin
                rdata_reg <= 32'(event_reg);
            end else if (HADDR_I[7:0] == ADDR_MASK) begin
                rdata_reg <= 32'(mask_reg);
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Threshold writes are clamped into the legal setting range.
    assign wdata_thr = (HWDATA_I[31:15] != 17'h0_0000) ? ZS_THRESHOLD_MAX :
        (HWDATA_I[14:0] < ZS_THRESHOLD_MIN) ? ZS_THRESHOLD_MIN :
        (HWDATA_I[14:0] > ZS_THRESHOLD_MAX) ? ZS_THRESHOLD_MAX : HWDATA_I[14:0];

    // Setting registers written in the data phase.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            zs_threshold_reg <= ZS_THRESHOLD_RST;
            pc_range_reg <= PC_RANGE_RST;
            pc_mode_reg <= PC_MODE_RST;
            uv_select_reg <= UV_SELECT_RST;
            detect_time_reg <= DETECT_TIME_RST;
            mask_reg <= 4'h0;
        end else if (wr_pend_reg) begin
            if (addr_reg == ADDR_ZS_THRESHOLD) begin
                zs_threshold_reg <= wdata_thr;
            end else if (addr_reg == ADDR_PC_RANGE) begin
                pc_range_reg <= HWDATA_I[14:0];
            end else if (addr_reg == ADDR_MODE) begin
                pc_mode_reg <= HWDATA_I[MODE_PC_LSB +: 2];
                uv_select_reg <= HWDATA_I[MODE_UV_BIT];
            end else if (addr_reg == ADDR_DETECT_TIME) begin
                detect_time_reg <= HWDATA_I[9:0];
            end else if (addr_reg == ADDR_MASK) begin
                mask_reg <= HWDATA_I[EV_WIDTH-1:0];
            end
        end
    end

    // Power pins come from another domain and pass two flip-flops first.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            pwr_sync1_reg <= 1'b1;
            pwr_sync2_reg <= 1'b1;
            bus_sync1_reg <= 1'b0;
            bus_sync2_reg <= 1'b0;
        end else begin
            pwr_sync1_reg <= MAIN_POWER_OK_I;
            pwr_sync2_reg <= pwr_sync1_reg;
            bus_sync1_reg <= DC_BUS_LOW_I;
            bus_sync2_reg <= bus_sync1_reg;
        end
    end

    // Shutoff must persist for the detection time; a value of 1000 disables timed detection.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            pwr_state_reg <= PWR_OK;
            tick_cnt_reg <= 32'h0000_0000;
            off_time_reg <= 10'h000;
        end else begin
            case (pwr_state_reg)
                PWR_OK: begin
                    tick_cnt_reg <= 32'h0000_0000;
                    off_time_reg <= 10'h000;
                    if (!pwr_sync2_reg && detect_time_reg != DETECT_TIME_OFF) begin
                        pwr_state_reg <= PWR_COUNT;
                    end
                end
                PWR_COUNT: begin
                    if (pwr_sync2_reg || detect_time_reg == DETECT_TIME_OFF) begin
                        pwr_state_reg <= PWR_OK;
                    end else if (off_time_reg >= detect_time_reg) begin
                        pwr_state_reg <= PWR_LOST;
                    end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
                        tick_cnt_reg <= 32'h0000_0000;
                        off_time_reg <= off_time_reg + 10'h001;
                    end else begin
                        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
                    end
                end
                PWR_LOST: begin
                    if (pwr_sync2_reg) begin
                        pwr_state_reg <= PWR_OK;
                    end
                end
                default: begin
                    pwr_state_reg <= PWR_OK;
                end
            endcase
        end
    end

    assign power_lost = (pwr_state_reg == PWR_LOST);

    // A low bus before detection completes always trips; a detected loss trips only with select 1.
    assign err_set = (bus_sync2_reg && !power_lost) ||
        (power_lost && !lost_prev_reg && servo_en_reg && uv_select_reg);
    assign err_clear = wr_pend_reg && (addr_reg == ADDR_CONTROL) && HWDATA_I[CTRL_CLR_ERR_BIT];

    // The error latches until software clears it; a new cause in the clear cycle wins.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            error_reg <= 1'b0;
        end else if (err_set) begin
            error_reg <= 1'b1;
        end else if (err_clear) begin
            error_reg <= 1'b0;
        end
    end

    // Servo follows the request except on a trip, while the error stays latched, or while power is lost.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            servo_en_reg <= 1'b0;
        end else begin
            servo_en_reg <= SERVO_ON_REQ_I && !error_reg && !err_set && !power_lost;
        end
    end

    // Deviation within plus or minus the range, inclusive.
    assign in_range = sus_abs(32'(DEVIATION_I)) <= 32'(pc_range_reg);
    assign no_cmd_ok = in_range && !POS_CMD_ACTIVE_I;

    // Mode qualification of the in-range test.
    always_comb begin
        case (sus_pc_mode_type'(pc_mode_reg))
            PC_ALWAYS: pc_cond = in_range;
            PC_NO_CMD: pc_cond = no_cmd_ok;
            PC_NO_CMD_ZS: pc_cond = no_cmd_ok && zero_speed;
            PC_HOLD: pc_cond = no_cmd_ok || (pc_held_reg && !(POS_CMD_ACTIVE_I && !cmd_prev_reg));
            default: pc_cond = in_range;
        endcase
    end

    // The hold latch is released only by the start of the next command or by leaving mode 3.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            pc_held_reg <= 1'b0;
            cmd_prev_reg <= 1'b0;
            pc_out_reg <= 1'b0;
        end else begin
            cmd_prev_reg <= POS_CMD_ACTIVE_I;
            pc_held_reg <= (pc_mode_reg == PC_HOLD) && pc_cond;
            pc_out_reg <= pc_cond;
        end
    end

    // Sticky events on rising edges, write one to clear, set wins over clear.
    assign ev_set = {error_reg && !err_prev_reg, power_lost && !lost_prev_reg,
        pc_out_reg && !pc_prev_reg, zero_speed && !zs_prev_reg};
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            event_reg <= 4'h0;
            zs_prev_reg <= 1'b0;
            pc_prev_reg <= 1'b0;
            lost_prev_reg <= 1'b0;
            err_prev_reg <= 1'b0;
        end else begin
            zs_prev_reg <= zero_speed;
            pc_prev_reg <= pc_out_reg;
            lost_prev_reg <= power_lost;
            err_prev_reg <= error_reg;
            if (wr_pend_reg && addr_reg == ADDR_EVENT) begin
                event_reg <= (event_reg & ~HWDATA_I[EV_WIDTH-1:0]) | ev_set;
            end else begin
                event_reg <= event_reg | ev_set;
            end
        end
    end

    assign IRQ_O = |(event_reg & mask_reg);
    assign ZERO_SPEED_OUT_O = zero_speed;
    assign POSITION_COMPLETE_OUT_O = pc_out_reg;
    assign SERVO_ENABLE_O = servo_en_reg;
    assign MAIN_UNDERVOLTAGE_ERROR_O = error_reg;

    // Checks start one edge after reset release, because the edge that releases reset still loads reset values.
    always_ff @(posedge CLK_I) begin
        chk_on_reg <= NRST_I;
    end

    sequence s_loss_detected;
        !power_lost ##1 power_lost;
    endsequence

    property p_mode0;
        @(posedge CLK_I) disable iff (!chk_on_reg) (pc_mode_reg == PC_ALWAYS) |=> (pc_out_reg == $past(in_range));
    endproperty
    a_mode0: assert property (p_mode0) else $error("Mode 0 output mismatch.");

    property p_mode1_cmd;
        @(posedge CLK_I) disable iff (!chk_on_reg) (pc_mode_reg == PC_NO_CMD && POS_CMD_ACTIVE_I) |=> !pc_out_reg;
    endproperty
    a_mode1_cmd: assert property (p_mode1_cmd) else $error("Mode 1 complete during command.");

    property p_mode2_zs;
        @(posedge CLK_I) disable iff (!chk_on_reg) (pc_mode_reg == PC_NO_CMD_ZS && !zero_speed) |=> !pc_out_reg;
    endproperty
    a_mode2_zs: assert property (p_mode2_zs) else $error("Mode 2 complete while moving.");

    property p_mode3_hold;
        @(posedge CLK_I) disable iff (!chk_on_reg)
            (pc_mode_reg == PC_HOLD && pc_out_reg && !POS_CMD_ACTIVE_I) ##1 (pc_mode_reg == PC_HOLD && !POS_CMD_ACTIVE_I)
            |=> pc_out_reg;
    endproperty
    a_mode3_hold: assert property (p_mode3_hold) else $error("Mode 3 dropped without command.");

    property p_loss_needs_time;
        @(posedge CLK_I) disable iff (!chk_on_reg) s_loss_detected |-> ($past(off_time_reg) >= detect_time_reg);
    endproperty
    a_loss_needs_time: assert property (p_loss_needs_time) else $error("Loss flagged too early.");

    property p_select1_trip;
        @(posedge CLK_I) disable iff (!chk_on_reg)
            (s_loss_detected ##0 (servo_en_reg && uv_select_reg)) |=> error_reg;
    endproperty
    a_select1_trip: assert property (p_select1_trip) else $error("Select 1 did not trip.");

    property p_select0_off;
        @(posedge CLK_I) disable iff (!chk_on_reg) power_lost |=> !servo_en_reg;
    endproperty
    a_select0_off: assert property (p_select0_off) else $error("Servo on while power lost.");

    property p_off_setting;
        @(posedge CLK_I) disable iff (!chk_on_reg)
            (detect_time_reg == DETECT_TIME_OFF && !power_lost) |=> !power_lost;
    endproperty
    a_off_setting: assert property (p_off_setting) else $error("Loss detected with 1000 setting.");

    property p_bus_low;
        @(posedge CLK_I) disable iff (!chk_on_reg) (bus_sync2_reg && !power_lost) |=> error_reg;
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("Low bus did not raise error.");

endmodule

// [sim/sus_host_model.sv]
`timescale 1ns/1ns
// Host motion controller model: it issues position commands and moves the motor,
// and it asks for servo-on for as long as it runs.
module sus_host_model (
    // Clock.
    input wire logic clk_i,
    // Motion lines towards the block.
    output logic signed [15:0] speed_o,
    output logic signed [23:0] deviation_o,
    output logic pos_cmd_o,
    output logic servo_on_o
);
    // Motor at rest, no command pending, servo-on requested from time zero.
    initial begin
        speed_o = 16'sh0000;
        deviation_o = 24'sh000000;
        pos_cmd_o = 1'b0;
        servo_on_o = 1'b1;
    end

    // All motion lines move together just after an edge, so the block never samples a half-updated set.
    task automatic set_motion(input logic signed [15:0] spd, input logic signed [23:0] dev, input logic cmd);
        @(posedge clk_i);
        speed_o <= spd;
        deviation_o <= dev;
        pos_cmd_o <= cmd;
    endtask
endmodule

// [sim/servo_status_and_undervoltage_seq_bench.sv]
`timescale 1ns/1ns
module servo_status_and_undervoltage_seq_bench;
    import sus_pkg::*;
    localparam int TICK = 4;
    localparam int LIMIT = 5000;
    logic clk, nrst, hsel, hwrite, hready, hresp, pos_cmd, servo_req, power_ok, bus_low;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic signed [15:0] speed;
    logic signed [23:0] dev;
    logic zs, pc, servo_en, uv_err, irq;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;

    // The single slave's ready is the bus ready.
    sus_top #(.TICK_CYCLES(TICK), .DEV_WIDTH(24)) u_dut (
        .CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .SPEED_I(speed),
        .DEVIATION_I(dev), .POS_CMD_ACTIVE_I(pos_cmd), .SERVO_ON_REQ_I(servo_req),
        .MAIN_POWER_OK_I(power_ok), .DC_BUS_LOW_I(bus_low), .ZERO_SPEED_OUT_O(zs),
        .POSITION_COMPLETE_OUT_O(pc), .SERVO_ENABLE_O(servo_en),
        .MAIN_UNDERVOLTAGE_ERROR_O(uv_err), .IRQ_O(irq));
    sus_host_model u_host (.clk_i(clk), .speed_o(speed), .deviation_o(dev), .pos_cmd_o(pos_cmd),
        .servo_on_o(servo_req));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cycle ceiling: a hung handshake must still end in the verdict.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single-word transfer; the wait for ready is bounded only by the cycle ceiling.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] unused;
        ahb(1'b1, a, wd, unused);
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h00000000, rd);
        check(rd, exp);
        check(hresp, 1'b0);
    endtask

    // Waits whole cycles, then lets that edge's updates settle before anything is sampled.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_pins(input logic ok, input logic low);
        @(posedge clk);
        power_ok <= ok;
        bus_low <= low;
    endtask

    task automatic test_settings();
        reg_check(ADDR_ZS_THRESHOLD, 32'h00000032);
        reg_check(ADDR_PC_RANGE, 32'h00000083);
        reg_check(ADDR_MODE, 32'h00000010);
        reg_check(ADDR_DETECT_TIME, 32'h00000046);
        reg_check(ADDR_MASK, 32'h00000000);
        reg_check(8'h20, 32'h00000000);
        wr(ADDR_ZS_THRESHOLD, 32'h00000005);
        reg_check(ADDR_ZS_THRESHOLD, 32'h0000000A);
        wr(ADDR_ZS_THRESHOLD, 32'h00007530);
        reg_check(ADDR_ZS_THRESHOLD, 32'h00004E20);
        wr(ADDR_ZS_THRESHOLD, 32'h00000032);
    endtask

    // Speeds on either side of the threshold, both outside and inside the hysteresis band and at its upper edge.
    task automatic test_zero_speed();
        u_host.set_motion(16'sh001E, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b1);
        u_host.set_motion(16'sh0046, 24'sh000000, 1'b0);
        step(1);
        check(zs, 1'b0);
        u_host.set_motion(16'shFFE2, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b1);
        u_host.set_motion(16'shFFBA, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b0);
        u_host.set_motion(16'sh0037, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b0);
        u_host.set_motion(16'sh0031, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b1);
        u_host.set_motion(16'shFFC5, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b1);
        u_host.set_motion(16'sh003C, 24'sh000000, 1'b0);
        step(3);
        check(zs, 1'b0);
    endtask

    task automatic pc_step(input logic signed [15:0] s, input logic signed [23:0] d, input logic c,
        input logic exp);
        u_host.set_motion(s, d, c);
        step(4);
        check(pc, exp);
    endtask

    task automatic test_pos_modes();
        pc_step(16'sh001E, 24'sh000083, 1'b1, 1'b1);
        pc_step(16'sh001E, 24'sh000084, 1'b0, 1'b0);
        pc_step(16'sh001E, 24'shFFFF7D, 1'b0, 1'b1);
        wr(ADDR_MODE, 32'h00000011);
        pc_step(16'sh001E, 24'sh000000, 1'b1, 1'b0);
        pc_step(16'sh001E, 24'sh000000, 1'b0, 1'b1);
        wr(ADDR_MODE, 32'h00000012);
        pc_step(16'sh0046, 24'sh000000, 1'b0, 1'b0);
        pc_step(16'sh001E, 24'sh000000, 1'b0, 1'b1);
        wr(ADDR_MODE, 32'h00000013);
        pc_step(16'sh001E, 24'sh000000, 1'b1, 1'b0);
        pc_step(16'sh001E, 24'sh000000, 1'b0, 1'b1);
        pc_step(16'sh001E, 24'sh0001F4, 1'b0, 1'b1);
        pc_step(16'sh001E, 24'sh0001F4, 1'b1, 1'b0);
        wr(ADDR_MODE, 32'h00000010);
        u_host.set_motion(16'sh001E, 24'sh000000, 1'b0);
    endtask

    // Default trip selection with a short detection time; the error also drives the interrupt.
    task automatic test_trip();
        wr(ADDR_DETECT_TIME, 32'h00000003);
        wr(ADDR_MASK, 32'h00000008);
        check(servo_en, 1'b1);
        set_pins(1'b0, 1'b0);
        step(8);
        check(uv_err, 1'b0);
        check(servo_en, 1'b1);
        step(32);
        check(uv_err, 1'b1);
        check(servo_en, 1'b0);
        check(irq, 1'b1);
        reg_check(ADDR_STATUS, 32'h0000000F);
        wr(ADDR_EVENT, 32'h00000008);
        step(2);
        check(irq, 1'b0);
        reg_check(ADDR_EVENT, 32'h00000007);
        set_pins(1'b1, 1'b0);
        step(6);
        wr(ADDR_CONTROL, 32'h00000001);
        step(3);
        check(uv_err, 1'b0);
        check(servo_en, 1'b1);
    endtask

    task automatic test_no_trip();
        wr(ADDR_MODE, 32'h00000000);
        set_pins(1'b0, 1'b0);
        step(40);
        check(uv_err, 1'b0);
        check(servo_en, 1'b0);
        set_pins(1'b1, 1'b0);
        step(10);
        check(servo_en, 1'b1);
        set_pins(1'b1, 1'b1);
        step(5);
        check(uv_err, 1'b1);
        set_pins(1'b1, 1'b0);
        step(3);
        wr(ADDR_CONTROL, 32'h00000001);
        step(3);
        check(uv_err, 1'b0);
    endtask

    // Timed detection switched off: only a low bus may still trip.
    task automatic test_detect_off();
        wr(ADDR_MODE, 32'h00000010);
        wr(ADDR_DETECT_TIME, 32'h000003E8);
        set_pins(1'b0, 1'b0);
        step(40);
        check(uv_err, 1'b0);
        check(servo_en, 1'b1);
        set_pins(1'b0, 1'b1);
        step(5);
        check(uv_err, 1'b1);
        check(servo_en, 1'b0);
        set_pins(1'b1, 1'b0);
        step(3);
        wr(ADDR_CONTROL, 32'h00000001);
        step(3);
        check(uv_err, 1'b0);
    endtask

    // Main sequence: inputs set at time zero, reset held for 20 cycles.
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        power_ok = 1'b1;
        bus_low = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        step(2);
        test_settings();
        test_zero_speed();
        test_pos_modes();
        test_trip();
        test_no_trip();
        test_detect_off();
        finish_test();
    end
endmodule
